// [rtl/alu_core_params.svh]
// Constants for the flag, operand addressing and result steering core.
// Assumes inclusion by its bare name from the package and the core module.
`ifndef ALU_CORE_PARAMS_SVH
`define ALU_CORE_PARAMS_SVH
// ==========================================================
// Flag bit positions and reset
`define FLAG_NEG 3'd4
`define FLAG_OVF 3'd3
`define FLAG_ZERO 3'd2
`define FLAG_DIG 3'd1
`define FLAG_CARRY 3'd0
`define FLAGS_RESET 5'h00
`define ACC_RESET 8'h00
// ==========================================================
// Data memory map: registers held inside the core, virtual pointer window and access bank split
`define FLAGS_ADDR 12'hFD8
`define BANK_ADDR 12'hFE0
`define PTR_BASE 12'hFE1
`define VIRT_BASE 12'hFE8
`define VIRT_END 12'hFFF
`define ACCESS_SPLIT 8'h60
`define ACCESS_HIGH 4'hF
`endif

// [rtl/alu_core_pkg.sv]
// Types shared by the core and its surroundings.
// Assumes the constants header sits beside it in rtl/.
`include "alu_core_params.svh"
package alu_core_pkg;
  // Operations seen by the flag and addressing logic
  typedef enum logic [3:0] {
    OP_NOP, OP_ADD_FILE, OP_ADD_LIT, OP_LIT_MINUS, OP_FILE_MINUS,
    OP_ROT_LEFT, OP_ROT_RIGHT, OP_BIT_CLR, OP_BIT_SET, OP_SWAP,
    OP_STORE_ACC, OP_MOVE_FF, OP_CLEAR_FILE, OP_AND_LIT, OP_JUMP
  } op_t;
  // Decoded instruction fields
  typedef struct packed {
    op_t op;
    logic [7:0] file_addr;
    logic [7:0] literal;
    logic access_bit;
    logic dest_bit;
    logic [2:0] bit_sel;
    logic [11:0] src_full;
    logic [11:0] dst_full;
    logic [19:0] prog_target;
  } instr_t;
  // Virtual pointer operand kinds
  typedef enum logic [2:0] {
    VK_PLAIN, VK_POST_INC, VK_POST_DEC, VK_PRE_INC, VK_PLUS_ACC
  } virt_kind_t;
endpackage

// [rtl/alu_flags_operand_addressing.sv]
// Flag register, accumulator, pointer pairs, operand addressing and result steering.
// Assumes a decoder on CLK feeding decoded instructions, and a data memory that
// answers DATA_ADDR with RD_DATA in the cycle that RD_EN stands.
`timescale 1ns/100ps
`include "alu_core_params.svh"
module alu_flags_operand_addressing #(
  parameter int NUM_PTRS = 3
) (
  input wire logic CLK, // Core clock, 200 MHz
  input wire logic RESET, // Synchronous reset, active high
  input wire logic INSTR_VALID, // Decoded instruction present
  input alu_core_pkg::instr_t INSTR, // Decoded instruction fields
  input wire logic EXT_SET_ENABLE, // Extended set configuration bit
  input wire logic [7:0] RD_DATA, // Data memory read value
  output logic READY, // Core can take an instruction
  output logic RD_EN, // Data memory read strobe
  output logic [11:0] DATA_ADDR, // Data memory read address
  output logic WR_EN, // Data memory write strobe
  output logic [11:0] WR_ADDR, // Data memory write address
  output logic [7:0] WR_DATA, // Data memory write value
  output logic [7:0] ACC, // Accumulator
  output logic [7:0] FLAGS, // Flag register view
  output logic JUMP_EN, // Program jump pulse
  output logic [19:0] JUMP_TARGET // Program jump destination
);
  import alu_core_pkg::*;

  // Elaboration check on the pointer pair count
  if (NUM_PTRS < 1 || NUM_PTRS > 3) begin : gen_bad_ptrs
    $error("NUM_PTRS must be 1 to 3");
  end

  typedef enum logic {ST_FETCH, ST_EXEC} state_t;

  state_t state_reg;
  instr_t stage_reg;
  logic [11:0] stage_addr_reg;
  logic [11:0] stage_wr_reg;
  logic [4:0] flags_reg;
  logic [7:0] acc_reg;
  logic [3:0] bank_reg;
  logic [11:0] ptr_reg [NUM_PTRS];

  // ==========================================================
  // Operand address forming
  logic [11:0] direct_addr;
  logic [11:0] fetch_addr;
  logic [11:0] ptr_next;
  logic [1:0] virt_idx;
  logic [2:0] virt_kind;
  logic [11:0] virt_off;
  logic virt_hit;
  logic fetch_reads;
  logic [11:0] acc_sext;

  // Direct address from opcode byte, bank and access bit
  always_comb begin
    if (INSTR.access_bit) begin
      direct_addr = {bank_reg, INSTR.file_addr};
    end else if (EXT_SET_ENABLE && INSTR.file_addr < `ACCESS_SPLIT && NUM_PTRS == 3) begin
      direct_addr = ptr_reg[NUM_PTRS-1] + {4'h0, INSTR.file_addr};
    end else if (INSTR.file_addr < `ACCESS_SPLIT) begin
      direct_addr = {4'h0, INSTR.file_addr};
    end else begin
      direct_addr = {`ACCESS_HIGH, INSTR.file_addr};
    end
  end

  // Virtual pointer operand decode and pointer arithmetic
  always_comb begin
    acc_sext = {{4{acc_reg[7]}}, acc_reg};
    virt_off = (INSTR.op == OP_MOVE_FF ? INSTR.src_full : direct_addr) - `VIRT_BASE;
    virt_idx = virt_off[4:3];
    virt_kind = virt_off[2:0];
    virt_hit = (INSTR.op != OP_MOVE_FF) && direct_addr >= `VIRT_BASE
      && direct_addr <= `VIRT_END && int'(virt_idx) < NUM_PTRS
      && virt_kind <= 3'(VK_PLUS_ACC);
    fetch_addr = (INSTR.op == OP_MOVE_FF) ? INSTR.src_full : direct_addr;
    ptr_next = 12'h000;
    if (virt_hit) begin
      ptr_next = ptr_reg[virt_idx];
      case (virt_kind)
        3'(VK_PLAIN): fetch_addr = ptr_reg[virt_idx];
        3'(VK_POST_INC): begin
          fetch_addr = ptr_reg[virt_idx];
          ptr_next = ptr_reg[virt_idx] + 12'h001;
        end
        3'(VK_POST_DEC): begin
          fetch_addr = ptr_reg[virt_idx];
          ptr_next = ptr_reg[virt_idx] - 12'h001;
        end
        3'(VK_PRE_INC): begin
          fetch_addr = ptr_reg[virt_idx] + 12'h001;
          ptr_next = fetch_addr;
        end
        default: fetch_addr = ptr_reg[virt_idx] + acc_sext;
      endcase
    end
    case (INSTR.op)
      OP_NOP, OP_ADD_LIT, OP_LIT_MINUS, OP_AND_LIT, OP_JUMP: fetch_reads = 1'b0;
      default: fetch_reads = 1'b1;
    endcase
  end

  // ==========================================================
  // Operand read and flag-setting arithmetic
  logic [7:0] operand;
  logic [7:0] alu_res;
  logic [4:0] alu_new;
  logic [4:0] alu_mask;
  logic [7:0] add_a;
  logic [7:0] add_b;
  logic add_c;
  logic is_add;
  logic [8:0] sum9;
  logic [4:0] nib5;
  logic [4:0] flags_merged;

  // Registers held here answer reads themselves
  always_comb begin
    operand = RD_DATA;
    if (stage_addr_reg == `FLAGS_ADDR) begin
      operand = {3'b000, flags_reg};
    end else if (stage_addr_reg == `BANK_ADDR) begin
      operand = {4'h0, bank_reg};
    end
    for (int i = 0; i < NUM_PTRS; i++) begin
      if (stage_addr_reg == `PTR_BASE + 12'(2 * i)) begin
        operand = ptr_reg[i][7:0];
      end else if (stage_addr_reg == `PTR_BASE + 12'(2 * i + 1)) begin
        operand = {4'h0, ptr_reg[i][11:8]};
      end
    end
  end

  // Result and flag outcome of the staged operation
  always_comb begin
    alu_res = 8'h00;
    alu_new = 5'h00;
    alu_mask = 5'h00;
    add_a = 8'h00;
    add_b = 8'h00;
    add_c = 1'b0;
    is_add = 1'b0;
    case (stage_reg.op)
      OP_ADD_FILE: begin
        add_a = operand;
        add_b = acc_reg;
        is_add = 1'b1;
      end
      OP_ADD_LIT: begin
        add_a = stage_reg.literal;
        add_b = acc_reg;
        is_add = 1'b1;
      end
      OP_LIT_MINUS: begin
        add_a = stage_reg.literal;
        add_b = ~acc_reg;
        add_c = 1'b1;
        is_add = 1'b1;
      end
      OP_FILE_MINUS: begin
        add_a = operand;
        add_b = ~acc_reg;
        add_c = 1'b1;
        is_add = 1'b1;
      end
      OP_ROT_LEFT: begin
        alu_res = {operand[6:0], flags_reg[`FLAG_CARRY]};
        alu_new[`FLAG_CARRY] = operand[7];
        alu_new[`FLAG_DIG] = operand[3];
        alu_mask = 5'h17;
      end
      OP_ROT_RIGHT: begin
        alu_res = {flags_reg[`FLAG_CARRY], operand[7:1]};
        alu_new[`FLAG_CARRY] = operand[0];
        alu_new[`FLAG_DIG] = operand[4];
        alu_mask = 5'h17;
      end
      OP_BIT_CLR: alu_res = operand & ~(8'h01 << stage_reg.bit_sel);
      OP_BIT_SET: alu_res = operand | (8'h01 << stage_reg.bit_sel);
      OP_SWAP: alu_res = {operand[3:0], operand[7:4]};
      OP_STORE_ACC: alu_res = acc_reg;
      OP_MOVE_FF: alu_res = operand;
      OP_CLEAR_FILE: alu_mask = 5'h04;
      OP_AND_LIT: begin
        alu_res = stage_reg.literal & acc_reg;
        alu_mask = 5'h14;
      end
      default: alu_res = 8'h00;
    endcase
    sum9 = {1'b0, add_a} + {1'b0, add_b} + {8'h00, add_c};
    nib5 = {1'b0, add_a[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_c};
    if (is_add) begin
      alu_res = sum9[7:0];
      alu_new[`FLAG_CARRY] = sum9[8];
      alu_new[`FLAG_DIG] = nib5[4];
      alu_new[`FLAG_OVF] = (add_a[7] == add_b[7]) && (sum9[7] != add_a[7]);
      alu_mask = 5'h1F;
    end
    alu_new[`FLAG_NEG] = alu_res[7];
    alu_new[`FLAG_ZERO] = (alu_res == 8'h00);
    flags_merged = (flags_reg & ~alu_mask) | (alu_new & alu_mask);
  end

  // Where the result goes
  logic to_file;
  logic to_acc;
  always_comb begin
    case (stage_reg.op)
      OP_ADD_FILE, OP_FILE_MINUS, OP_ROT_LEFT, OP_ROT_RIGHT, OP_SWAP: begin
        to_file = stage_reg.dest_bit;
        to_acc = !stage_reg.dest_bit;
      end
      OP_ADD_LIT, OP_LIT_MINUS, OP_AND_LIT: begin
        to_file = 1'b0;
        to_acc = 1'b1;
      end
      OP_BIT_CLR, OP_BIT_SET, OP_STORE_ACC, OP_MOVE_FF, OP_CLEAR_FILE: begin
        to_file = 1'b1;
        to_acc = 1'b0;
      end
      default: begin
        to_file = 1'b0;
        to_acc = 1'b0;
      end
    endcase
  end

  logic exec_now;
  logic fetch_now;
  logic wr_flags;
  logic wr_internal;
  assign exec_now = (state_reg == ST_EXEC);
  assign fetch_now = (state_reg == ST_FETCH) && INSTR_VALID;
  assign wr_flags = exec_now && to_file && stage_wr_reg == `FLAGS_ADDR;
  assign wr_internal = stage_wr_reg == `FLAGS_ADDR || stage_wr_reg == `BANK_ADDR
    || (stage_wr_reg >= `PTR_BASE && stage_wr_reg < `PTR_BASE + 12'(2 * NUM_PTRS));

  // ==========================================================
  // Sequencing: fetch stage then execute stage
  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_reg <= ST_FETCH;
      stage_reg <= '0;
      stage_addr_reg <= 12'h000;
      stage_wr_reg <= 12'h000;
    end else if (fetch_now) begin
      state_reg <= ST_EXEC;
      stage_reg <= INSTR;
      stage_addr_reg <= fetch_reads ? fetch_addr : 12'h000;
      stage_wr_reg <= (INSTR.op == OP_MOVE_FF) ? INSTR.dst_full : fetch_addr;
    end else if (exec_now) begin
      state_reg <= ST_FETCH;
    end
  end

  // Memory read request and jump pulse
  always_ff @(posedge CLK) begin
    if (RESET) begin
      RD_EN <= 1'b0;
      DATA_ADDR <= 12'h000;
      JUMP_EN <= 1'b0;
      JUMP_TARGET <= 20'h0_0000;
      READY <= 1'b0;
    end else begin
      RD_EN <= fetch_now && fetch_reads;
      DATA_ADDR <= fetch_now ? fetch_addr : DATA_ADDR;
      JUMP_EN <= fetch_now && INSTR.op == OP_JUMP;
      JUMP_TARGET <= (fetch_now && INSTR.op == OP_JUMP) ? INSTR.prog_target : JUMP_TARGET;
      READY <= !fetch_now;
    end
  end

  // Flag register
  always_ff @(posedge CLK) begin
    if (RESET) begin
      flags_reg <= `FLAGS_RESET;
    end else if (wr_flags && alu_mask != 5'h00) begin
      flags_reg <= flags_merged;
    end else if (wr_flags) begin
      flags_reg <= alu_res[4:0];
    end else if (exec_now) begin
      flags_reg <= flags_merged;
    end
  end

  // Accumulator and bank selector
  always_ff @(posedge CLK) begin
    if (RESET) begin
      acc_reg <= `ACC_RESET;
      bank_reg <= 4'h0;
    end else if (exec_now) begin
      if (to_acc) begin
        acc_reg <= alu_res;
      end
      if (to_file && stage_wr_reg == `BANK_ADDR) begin
        bank_reg <= alu_res[3:0];
      end
    end
  end

  // Pointer pairs: auto update at fetch, direct writes at execute
  generate
    for (genvar g = 0; g < NUM_PTRS; g++) begin : gen_ptr
      always_ff @(posedge CLK) begin
        if (RESET) begin
          ptr_reg[g] <= 12'h000;
        end else if (fetch_now && virt_hit && int'(virt_idx) == g) begin
          ptr_reg[g] <= ptr_next;
        end else if (exec_now && to_file && stage_wr_reg == `PTR_BASE + 12'(2 * g)) begin
          ptr_reg[g][7:0] <= alu_res;
        end else if (exec_now && to_file && stage_wr_reg == `PTR_BASE + 12'(2 * g + 1)) begin
          ptr_reg[g][11:8] <= alu_res[3:0];
        end
      end
    end
  endgenerate

  // External file write
  always_ff @(posedge CLK) begin
    if (RESET) begin
      WR_EN <= 1'b0;
      WR_ADDR <= 12'h000;
      WR_DATA <= 8'h00;
    end else begin
      WR_EN <= exec_now && to_file && !wr_internal;
      WR_ADDR <= exec_now ? stage_wr_reg : WR_ADDR;
      WR_DATA <= exec_now ? alu_res : WR_DATA;
    end
  end

  // Visible copies of the accumulator and flags
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ACC <= `ACC_RESET;
      FLAGS <= 8'h00;
    end else begin
      ACC <= acc_reg;
      FLAGS <= {3'b000, flags_reg};
    end
  end
endmodule

// [verif/alu_flags_sva.sv]
// Checker for the flag and operand addressing core, bound to its ports.
// Assumes the core package is compiled first.
`timescale 1ns/100ps
module alu_flags_sva (
  input wire logic CLK, // Core clock
  input wire logic RESET, // Sync reset
  input wire logic INSTR_VALID, // Instruction present
  input alu_core_pkg::instr_t INSTR, // Instruction fields
  input wire logic EXT_SET_ENABLE, // Extended set bit
  input wire logic READY, // Take allowed
  input wire logic RD_EN, // Read strobe
  input wire logic WR_EN, // Write strobe
  input wire logic [11:0] WR_ADDR, // Write address
  input wire logic [11:0] DATA_ADDR, // Read address
  input wire logic [7:0] FLAGS, // Flag view
  input wire logic JUMP_EN, // Jump pulse
  input wire logic [19:0] JUMP_TARGET // Jump destination
);
  import alu_core_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  // ==========
  // Instruction takes
  logic take;
  assign take = INSTR_VALID && READY;
  sequence s_addf;
    take && INSTR.op == OP_ADD_FILE;
  endsequence
  sequence s_keep;
    take && INSTR.op inside {OP_BIT_CLR, OP_BIT_SET, OP_SWAP, OP_STORE_ACC, OP_MOVE_FF}
      && INSTR.file_addr != 8'hd8 && INSTR.dst_full != 12'hfd8;
  endsequence
  // ==========
  // Properties
  a_flag_top_zero: assert property (FLAGS[7:5] == 3'h0)
    else $error("flag top bits not zero");
  a_jump_dest: assert property (take && INSTR.op == OP_JUMP |=>
    JUMP_EN && JUMP_TARGET == $past(INSTR.prog_target)) else $error("jump target wrong");
  a_jump_quiet: assert property (take && INSTR.op != OP_JUMP |=> !JUMP_EN)
    else $error("jump without jump op");
  a_flags_kept: assert property (s_keep |=> ##1 $stable(FLAGS) [*2])
    else $error("flags moved by flag-neutral op");
  a_acc_no_write: assert property (s_addf ##0 !INSTR.dest_bit |=> ##1 !WR_EN)
    else $error("memory written for accumulator result");
  a_bank_low: assert property (s_addf ##0 (INSTR.access_bit && INSTR.file_addr < 8'h80)
    |=> DATA_ADDR[7:0] == $past(INSTR.file_addr)) else $error("banked low byte wrong");
  a_access_low: assert property (s_addf ##0 (!INSTR.access_bit && !EXT_SET_ENABLE
    && INSTR.file_addr < 8'h60) |=> DATA_ADDR == {4'h0, $past(INSTR.file_addr)})
    else $error("access bank address wrong");
  a_full_src: assert property (take && INSTR.op == OP_MOVE_FF && INSTR.src_full < 12'hf00
    |=> DATA_ADDR == $past(INSTR.src_full)) else $error("full source address wrong");
  a_write_back: assert property (s_addf ##0 (INSTR.dest_bit && INSTR.access_bit
    && INSTR.file_addr < 8'h80) |=> ##1 WR_EN && WR_ADDR == $past(DATA_ADDR))
    else $error("result not written to source");
  a_read_strobe: assert property (s_addf |=> RD_EN)
    else $error("no operand read for file add");
  a_lit_no_read: assert property (take && INSTR.op == OP_ADD_LIT |=> !RD_EN)
    else $error("memory read for literal add");
endmodule
bind alu_flags_operand_addressing alu_flags_sva u_sva (.CLK(CLK), .RESET(RESET),
  .INSTR_VALID(INSTR_VALID), .INSTR(INSTR), .EXT_SET_ENABLE(EXT_SET_ENABLE),
  .READY(READY), .RD_EN(RD_EN), .WR_EN(WR_EN), .WR_ADDR(WR_ADDR), .DATA_ADDR(DATA_ADDR),
  .FLAGS(FLAGS), .JUMP_EN(JUMP_EN), .JUMP_TARGET(JUMP_TARGET));

// [verif/alu_flags_operand_addressing_bench.sv]
// Self-checking bench for the flag and operand addressing core.
// Assumes package, core and checker compiled first; RD_DATA stands for memory.
`timescale 1ns/100ps
module alu_flags_operand_addressing_bench;
  import alu_core_pkg::*;
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  logic INSTR_VALID = 1'b0;
  logic EXT_SET_ENABLE = 1'b0;
  instr_t INSTR = '0;
  logic [7:0] RD_DATA = 8'h00;
  logic READY, RD_EN, WR_EN, JUMP_EN;
  logic [11:0] DATA_ADDR, WR_ADDR;
  logic [7:0] WR_DATA, ACC, FLAGS, acc_m, v;
  logic [19:0] JUMP_TARGET;
  logic [4:0] fl_m;
  logic [12:0] r;
  logic [19:0] exp_wr[$];
  logic [19:0] exp_jump[$];
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  alu_flags_operand_addressing u_dut (.CLK(CLK), .RESET(RESET), .INSTR_VALID(INSTR_VALID),
    .INSTR(INSTR), .EXT_SET_ENABLE(EXT_SET_ENABLE), .RD_DATA(RD_DATA), .READY(READY),
    .RD_EN(RD_EN),
    .DATA_ADDR(DATA_ADDR), .WR_EN(WR_EN), .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA), .ACC(ACC),
    .FLAGS(FLAGS), .JUMP_EN(JUMP_EN), .JUMP_TARGET(JUMP_TARGET));
  // ==========
  // Clock, timeout and shared tasks
  always #2.5 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic check(input string what, input logic [19:0] seen, input logic [19:0] want);
    n_compared++;
    if (seen !== want) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic give_verdict();
    if (n_fail == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Sum with flags {neg, wrap, zero, nibble carry, carry, result}
  function automatic logic [12:0] ar(input logic [7:0] a, input logic [7:0] b, input logic c);
    logic [8:0] s;
    logic [4:0] d;
    s = a + b + c;
    d = a[3:0] + b[3:0] + c;
    return {s[7], a[7] == b[7] && s[7] != a[7], s[7:0] == 8'h00, d[4], s[8], s[7:0]};
  endfunction
  // One instruction, then accumulator and flags against the model
  task automatic run(input op_t op, input logic [7:0] f, input logic a, input logic d);
    @(posedge CLK);
    INSTR <= '{op: op, file_addr: f, literal: v, access_bit: a, dest_bit: d, bit_sel: 3'h0,
      src_full: 12'h123, dst_full: 12'h456, prog_target: {4'h0, v, v}};
    RD_DATA <= v;
    INSTR_VALID <= 1'b1;
    @(posedge CLK);
    INSTR_VALID <= 1'b0;
    @(posedge CLK);
    RD_DATA <= ~v;
    repeat (4) @(posedge CLK);
    #1;
    check("acc", 20'(ACC), 20'(acc_m));
    check("flags", 20'(FLAGS), 20'({3'h0, fl_m}));
  endtask
  task automatic add_lit(input logic [7:0] x);
    v = x;
    {fl_m, acc_m} = ar(acc_m, v, 1'b0);
    run(OP_ADD_LIT, 8'h00, 1'b0, 1'b0);
  endtask
  // Watcher of writes and jumps against the oldest note, mid-cycle
  always @(negedge CLK) begin
    if (WR_EN === 1'b1)
      check("write", {WR_ADDR, WR_DATA}, exp_wr.size() ? exp_wr.pop_front() : ~{WR_ADDR, WR_DATA});
    if (JUMP_EN === 1'b1)
      check("jump", JUMP_TARGET, exp_jump.size() ? exp_jump.pop_front() : ~JUMP_TARGET);
  end
  // ==========
  // Main sequence
  initial begin
    void'($urandom(85));
    repeat (20) @(posedge CLK);
    RESET <= 1'b0;
    repeat (3) @(posedge CLK);
    #1;
    acc_m = 8'h00;
    fl_m = 5'h00;
    check("reset flags", 20'(FLAGS), 20'h0_0000);
    // Literal adds then literal minus accumulator, each with a zero case
    for (int i = 0; i < 6; i++) begin
      v = (i == 2) ? 8'h00 - acc_m : (i == 5) ? acc_m : 8'($urandom);
      r = (i < 3) ? ar(acc_m, v, 1'b0) : ar(v, ~acc_m, 1'b1);
      {fl_m, acc_m} = r;
      run(i < 3 ? OP_ADD_LIT : OP_LIT_MINUS, 8'h00, 1'b0, 1'b0);
    end
    // Bank selector set to 2, then an access bank store
    add_lit(8'h02 - acc_m);
    run(OP_STORE_ACC, 8'he0, 1'b0, 1'b1);
    exp_wr.push_back({12'h020, acc_m});
    run(OP_STORE_ACC, 8'h20, 1'b0, 1'b1);
    // Banked add written back, then add into the accumulator
    v = 8'($urandom);
    r = ar(v, acc_m, 1'b0);
    fl_m = r[12:8];
    exp_wr.push_back({12'h234, r[7:0]});
    run(OP_ADD_FILE, 8'h34, 1'b1, 1'b1);
    v = 8'($urandom);
    {fl_m, acc_m} = ar(v, acc_m, 1'b0);
    run(OP_ADD_FILE, 8'h10, 1'b0, 1'b0);
    // Flag register as destination takes the outcome only
    r = ar({3'h0, fl_m}, acc_m, 1'b0);
    fl_m = r[12:8];
    run(OP_ADD_FILE, 8'hd8, 1'b0, 1'b1);
    v = 8'($urandom);
    exp_wr.push_back({12'h456, v});
    run(OP_MOVE_FF, 8'h00, 1'b0, 1'b0);
    // Rotates through carry, left then right
    for (int i = 0; i < 2; i++) begin
      v = 8'($urandom);
      r[7:0] = i ? {fl_m[0], v[7:1]} : {v[6:0], fl_m[0]};
      fl_m = {r[7], fl_m[3], r[7:0] == 8'h00, i ? v[4] : v[3], i ? v[0] : v[7]};
      acc_m = r[7:0];
      run(i ? OP_ROT_RIGHT : OP_ROT_LEFT, 8'h10, 1'b0, 1'b0);
    end
    v = 8'($urandom);
    exp_jump.push_back({4'h0, v, v});
    run(OP_JUMP, 8'h00, 1'b0, 1'b0);
    // Pointer at 0x0FF: post increments roll over, then plus accumulator of -1
    add_lit(8'hff - acc_m);
    run(OP_STORE_ACC, 8'he1, 1'b0, 1'b1);
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      r = ar(v, acc_m, 1'b0);
      fl_m = r[12:8];
      exp_wr.push_back({i == 0 ? 12'h0ff : 12'h100, r[7:0]});
      run(OP_ADD_FILE, i < 2 ? 8'he9 : 8'hec, 1'b0, 1'b1);
    end
    // Bit set, bit clear and swap written back with flags kept
    for (int i = 0; i < 3; i++) begin
      v = 8'($urandom);
      exp_wr.push_back({12'h030, i == 0 ? v | 8'h01 : i == 1 ? v & 8'hfe : {v[3:0], v[7:4]}});
      run(i == 0 ? OP_BIT_SET : i == 1 ? OP_BIT_CLR : OP_SWAP, 8'h30, 1'b0, 1'b1);
    end
    // Clear of the flag register sets zero only, then a memory clear
    fl_m[2] = 1'b1;
    run(OP_CLEAR_FILE, 8'hd8, 1'b0, 1'b1);
    exp_wr.push_back({12'h031, 8'h00});
    run(OP_CLEAR_FILE, 8'h31, 1'b0, 1'b1);
    // Literal mask moves negative and zero only
    v = 8'($urandom);
    acc_m = acc_m & v;
    fl_m[4] = acc_m[7];
    fl_m[2] = (acc_m == 8'h00);
    run(OP_AND_LIT, 8'h00, 1'b0, 1'b0);
    // File minus accumulator into the accumulator
    v = 8'($urandom);
    {fl_m, acc_m} = ar(v, ~acc_m, 1'b1);
    run(OP_FILE_MINUS, 8'h40, 1'b0, 1'b0);
    // Pointer 2 from the accumulator, then an indexed literal offset add
    run(OP_STORE_ACC, 8'he5, 1'b0, 1'b1);
    @(posedge CLK);
    EXT_SET_ENABLE <= 1'b1;
    v = 8'($urandom);
    r = ar(v, acc_m, 1'b0);
    fl_m = r[12:8];
    exp_wr.push_back({12'({4'h0, acc_m}) + 12'h005, r[7:0]});
    run(OP_ADD_FILE, 8'h05, 1'b0, 1'b1);
    @(posedge CLK);
    EXT_SET_ENABLE <= 1'b0;
    check("pending", 20'(exp_wr.size() + exp_jump.size()), 20'h0_0000);
    give_verdict();
  end
endmodule
